// file: rtl/deadband_prs.sv
/*
  Dead-band generator and pseudo-random sequence generator sharing one 8-bit block.
  Assumes a one-cycle tick for the selected block clock, the previous block's
  primary output as waveform input, and control bits driven as plain ports.
*/
`timescale 1ns/100ps
module deadband_prs #(
  parameter int DATA_W = dbprs_pkg::DATA_W
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_tick,
  input  wire logic              wave_in,
  input  wire logic              force_low,
  input  wire logic              force_low_ext,
  input  wire logic              chain_in,
  input  wire logic              chain_fb_in,
  input  wire dbprs_pkg::ctrl_t  ctrl,
  output logic                   primary_phase_out,
  output logic                   complementary_phase_out,
  output logic                   chain_out,
  output logic                   chain_fb_out,
  output logic                   irq,
  output logic [DATA_W-1:0]      rd_data,
  output logic [DATA_W-1:0]      stream_data,
  output logic                   stream_valid,
  input  wire logic              stream_ready,
  output logic                   stream_overflow
);
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_DEAD_HI = 4'h2,
    ST_PRI_HI  = 4'h4,
    ST_DEAD_LO = 4'h8
  } db_state_t;

  db_state_t          state;
  logic [DATA_W-1:0]  period;
  logic [DATA_W-1:0]  counter;
  logic [DATA_W-1:0]  poly;
  logic [DATA_W-1:0]  seed;
  logic [DATA_W-1:0]  lfsr;
  logic [DATA_W-1:0]  next_lfsr;
  logic [DATA_W-1:0]  capture;
  logic               wave_d;
  logic               kill_meta;
  logic               kill_sync;
  logic               kill;
  logic               pri;
  logic               comp;
  logic               pri_d;
  logic               run;
  logic               wave_rise;
  logic               wave_fall;
  logic               ser_bit;
  logic               fifo_in_ready;
  logic [3:0]         bit_cnt;
  logic [DATA_W-1:0]  shreg;
  logic               push;
  logic [DATA_W-1:0]  len_mask;
  logic               db_gate;
  logic               next_pri_out;
  logic               next_comp_out;
  logic               next_chain_out;

  // tap selection: top set bit of the polynomial marks the length
  function automatic logic msb_of(input logic [DATA_W-1:0] p, input logic [DATA_W-1:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      if (p[i]) begin
        r = v[i];
      end
    end
    return r;
  endfunction : msb_of

  // active length: every stage at or below the top set polynomial bit.
  // stages above it must stay clear, or a short sequence never meets its seed
  function automatic logic [DATA_W-1:0] span_of(input logic [DATA_W-1:0] p);
    logic [DATA_W-1:0] m;
    logic              seen;
    m    = '0;
    seen = 1'b0;
    for (int i = DATA_W-1; i >= 0; i--) begin
      seen = seen | p[i];
      m[i] = seen;
    end
    return m;
  endfunction : span_of

  assign len_mask = span_of(poly);

  assign run       = ctrl.enable;
  assign wave_rise = wave_in && !wave_d;
  assign wave_fall = !wave_in && wave_d;
  assign kill      = force_low || kill_sync;

  // feedback bit enters at bit 0 and XORs into each tapped stage
  assign ser_bit = ctrl.prs_mode ? (msb_of(poly, lfsr) ^ chain_fb_in) : 1'b0;
  always_comb begin
    next_lfsr = {lfsr[DATA_W-2:0], chain_in};
    for (int i = 1; i < DATA_W; i++) begin
      if (poly[i-1]) begin
        next_lfsr[i] = lfsr[i-1] ^ ser_bit;
      end
    end
    next_lfsr[0] = chain_in ^ ser_bit;
    next_lfsr    = next_lfsr & len_mask;
  end

  // one gate for all dead-band copies, so the chain output never leads
  // or lags the primary pin by a cycle at an input edge
  always_comb begin
    db_gate        = !kill && !wave_rise && !wave_fall;
    next_pri_out   = pri && db_gate;
    next_comp_out  = comp && !pri && db_gate;
    next_chain_out = pri && db_gate;
  end

  // two flops only; the second is the only reader of the first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kill_meta <= 1'b0;
      kill_sync <= 1'b0;
    end else begin
      kill_meta <= force_low_ext;
      kill_sync <= kill_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      period <= dbprs_pkg::PERIOD_RESET;
      poly   <= dbprs_pkg::POLY_RESET;
      seed   <= dbprs_pkg::SEED_RESET;
    end else begin
      if (ctrl.period_wr) begin
        period <= ctrl.period_wdata;
      end
      if (ctrl.poly_wr) begin
        poly <= ctrl.poly_wdata;
      end
      if (ctrl.seed_wr) begin
        seed <= ctrl.seed_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wave_d <= 1'b0;
    end else if (run && !ctrl.prs_mode) begin
      wave_d <= wave_in;
    end
  end

  // dead-band sequencer: counter reloads on every input edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state   <= ST_IDLE;
      counter <= dbprs_pkg::PERIOD_RESET;
      pri     <= 1'b0;
      comp    <= 1'b0;
    end else if (!run) begin
      pri  <= 1'b0;
      comp <= 1'b0;
      if (ctrl.period_wr && !ctrl.prs_mode) begin
        counter <= ctrl.period_wdata;
      end
      state <= ST_IDLE;
    end else if (!ctrl.prs_mode) begin
      if (wave_rise) begin
        comp    <= 1'b0;
        pri     <= 1'b0;
        counter <= period;
        state   <= ST_DEAD_HI;
      end else if (wave_fall) begin
        pri     <= 1'b0;
        comp    <= 1'b0;
        counter <= period;
        state   <= ST_DEAD_LO;
      end else begin
        unique case (state)
          ST_IDLE: begin
            state <= wave_in ? ST_DEAD_HI : ST_DEAD_LO;
          end
          ST_DEAD_HI: begin
            if (clk_tick) begin
              if (counter == '0) begin
                pri   <= 1'b1;
                state <= ST_PRI_HI;
              end else begin
                counter <= counter - 1'b1;
              end
            end
          end
          ST_PRI_HI: begin
            pri <= 1'b1;
          end
          ST_DEAD_LO: begin
            if (clk_tick) begin
              if (counter == '0) begin
                comp  <= 1'b1;
                state <= ST_IDLE;
              end else begin
                counter <= counter - 1'b1;
              end
            end
          end
        endcase
        if (state == ST_IDLE && !wave_in && comp) begin
          state <= ST_IDLE;
        end
      end
    end
  end

  // holds because each edge drops both phases before either rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      primary_phase_out       <= 1'b0;
      complementary_phase_out <= 1'b0;
      chain_out               <= 1'b0;
      chain_fb_out            <= 1'b0;
      pri_d                   <= 1'b0;
      irq                     <= 1'b0;
    end else if (!run) begin
      primary_phase_out       <= 1'b0;
      complementary_phase_out <= 1'b0;
      chain_out               <= 1'b0;
      chain_fb_out            <= 1'b0;
      pri_d                   <= 1'b0;
      irq                     <= 1'b0;
    end else if (!ctrl.prs_mode) begin
      primary_phase_out       <= next_pri_out;
      complementary_phase_out <= next_comp_out;
      chain_out               <= next_chain_out;
      chain_fb_out            <= 1'b0;
      pri_d                   <= pri && !kill;
      irq                     <= pri && !kill && !pri_d;
    end else begin
      primary_phase_out       <= 1'b0;
      complementary_phase_out <= 1'b0;
      chain_fb_out            <= msb_of(poly, lfsr);
      if (clk_tick) begin
        chain_out <= msb_of(poly, next_lfsr);
        irq       <= (next_lfsr == seed);
      end else begin
        irq <= 1'b0;
      end
    end
  end

  // LFSR: seed load only while stopped, state kept across disable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfsr <= dbprs_pkg::SEED_RESET;
    end else if (!run) begin
      if (ctrl.seed_wr) begin
        lfsr <= ctrl.seed_wdata;
      end
    end else if (ctrl.prs_mode && clk_tick) begin
      lfsr <= next_lfsr;
    end
  end

  // read of the LFSR byte answers zero and captures for the next read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capture <= '0;
      rd_data <= '0;
    end else begin
      if (!run && ctrl.lfsr_rd) begin
        capture <= lfsr;
        rd_data <= '0;
      end else if (!run && ctrl.capture_rd) begin
        rd_data <= capture;
      end
    end
  end

  // pack serial bits into bytes for the downstream FIFO
  assign push = run && ctrl.prs_mode && clk_tick && (bit_cnt == 4'(DATA_W-1));
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_cnt         <= '0;
      shreg           <= '0;
      stream_overflow <= 1'b0;
    end else if (run && ctrl.prs_mode && clk_tick) begin
      shreg   <= {shreg[DATA_W-2:0], msb_of(poly, next_lfsr)};
      bit_cnt <= (bit_cnt == 4'(DATA_W-1)) ? '0 : bit_cnt + 1'b1;
      // bytes are dropped rather than stalling the sequence, flagged sticky
      if (push && !fifo_in_ready) begin
        stream_overflow <= 1'b1;
      end
    end
  end

  sample_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (dbprs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   ({shreg[DATA_W-2:0], msb_of(poly, next_lfsr)}),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (stream_data),
    .out_valid (stream_valid),
    .out_ready (stream_ready)
  );
endmodule : deadband_prs

// file: rtl/dbprs_pkg.sv
/*
  Shared constants and carrier types for the dead-band / pseudo-random block.
  Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
package dbprs_pkg;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  PERIOD_RESET   = 8'h00;
  localparam logic [7:0]  POLY_RESET     = 8'h00;
  localparam logic [7:0]  SEED_RESET     = 8'h00;
  localparam int          SYS_CLK_MHZ    = 250;
  // force-low resync latency budget, in ns
  localparam int          KILL_LAT_NS    = 42;
  localparam int          KILL_SYNC_CYC  = (KILL_LAT_NS * SYS_CLK_MHZ) / 1000;
  localparam int          FIFO_DEPTH     = 32;

  typedef enum logic [1:0] {
    MODE_DEADBAND = 2'h1,
    MODE_PRS      = 2'h2
  } mode_t;

  typedef struct packed {
    logic       enable;
    logic       prs_mode;
    logic       period_wr;
    logic [7:0] period_wdata;
    logic       poly_wr;
    logic [7:0] poly_wdata;
    logic       seed_wr;
    logic [7:0] seed_wdata;
    logic       lfsr_rd;
    logic       capture_rd;
  } ctrl_t;

  typedef struct packed {
    logic       primary_phase_out;
    logic       complementary_phase_out;
    logic       chain_out;
    logic       irq;
  } outs_t;
endpackage : dbprs_pkg

// file: rtl/sample_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock; full and empty are exact.
*/
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

// file: bench/deadband_prs_chk.sv
/* port assertions for deadband_prs, bound after the module.
   assumes one clock domain with synchronous active-high reset */
`timescale 1ns/100ps
module deadband_prs_chk #(
  parameter int DATA_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              clk_tick,
  input wire logic              wave_in,
  input wire logic              force_low,
  input wire logic              force_low_ext,
  input wire dbprs_pkg::ctrl_t  ctrl,
  input wire logic              primary_phase_out,
  input wire logic              complementary_phase_out,
  input wire logic              chain_out,
  input wire logic              irq,
  input wire logic [DATA_W-1:0] rd_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire db = ctrl.enable && !ctrl.prs_mode;
  sequence s_in_rise;
    db && !force_low && $rose(wave_in);
  endsequence
  sequence s_in_fall;
    db && $fell(wave_in);
  endsequence
  a_no_overlap: assert property (!(primary_phase_out && complementary_phase_out))
    else $error("both phases high");
  a_rise_comp: assert property (s_in_rise |-> ##[1:2] !complementary_phase_out)
    else $error("complementary still high after input rise");
  a_fall_prim: assert property (s_in_fall |-> ##[1:2] !primary_phase_out)
    else $error("primary still high after input fall");
  a_kill_low: assert property (force_low [*2] |-> !primary_phase_out && !complementary_phase_out)
    else $error("output high under force low");
  a_ext_kill: assert property (force_low_ext [*4] |-> !primary_phase_out && !complementary_phase_out)
    else $error("output high under external force low");
  a_off_quiet: assert property (!ctrl.enable [*2] |-> !primary_phase_out && !complementary_phase_out && !chain_out && !irq)
    else $error("output active while disabled");
  a_irq_rise: assert property (db && $rose(primary_phase_out) |-> ##[0:1] irq)
    else $error("no interrupt on primary rise");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
  a_chain_prim: assert property (db && $past(db) |-> chain_out == primary_phase_out)
    else $error("chain output differs from primary");
  a_serial_tick: assert property (ctrl.prs_mode && ctrl.enable && $past(ctrl.enable)
    && $changed(chain_out) |-> $past(clk_tick) || $past(clk_tick, 2))
    else $error("serial bit changed without tick");
  a_rd_zero: assert property (!ctrl.enable && ctrl.lfsr_rd |=> rd_data == {DATA_W{1'b0}})
    else $error("shift register read not zero");
endmodule : deadband_prs_chk

bind deadband_prs deadband_prs_chk #(.DATA_W(DATA_W)) u_chk (.sys_clk, .rst, .clk_tick,
  .wave_in, .force_low, .force_low_ext, .ctrl, .primary_phase_out,
  .complementary_phase_out, .chain_out, .irq, .rd_data);

// file: bench/pwm_src_model.sv
/* preceding pwm block: tick divider and a wave with set high/low tick counts.
   assumes lengths stay above the dead time while run is high */
`timescale 1ns/100ps
module pwm_src_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [8:0] hi_len,
  input  wire logic [8:0] lo_len,
  output logic            clk_tick,
  output logic            wave_in
);
  logic [1:0] div;
  logic [8:0] left;
  always_ff @(posedge sys_clk) begin
    div      <= rst ? 2'h0 : div + 2'h1;
    clk_tick <= !rst && div == 2'h2;
  end
  // wave stays low while stopped so the block never sees a stale level
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      wave_in <= 1'b0;
      left    <= lo_len;
    end else if (clk_tick) begin
      if (left == 9'h000) begin
        wave_in <= !wave_in;
        left    <= wave_in ? lo_len : hi_len;
      end else begin
        left <= left - 9'h001;
      end
    end
  end
endmodule : pwm_src_model

// file: bench/tb.sv
/* self-checking bench for deadband_prs driven by a pwm source model.
   assumes a 250 MHz sys_clk and the package's default width */
`timescale 1ns/100ps
module tb;
  logic             sys_clk, rst, en, prs, run, force_low, force_low_ext, stream_ready;
  logic [4:0]       strb;
  logic [7:0]       wd, p, seed, rd_data, s_data;
  logic [8:0]       hi_len, lo_len;
  logic             clk_tick, wave_in, prim, comp, chain_out, irq, s_valid, ovf;
  int               errors, cmp_count, cyc, n;
  dbprs_pkg::ctrl_t ctrl;
  assign ctrl = {en, prs, strb[0], wd, strb[1], wd, strb[2], wd, strb[3], strb[4]};
  pwm_src_model u_src (.sys_clk, .rst, .run, .hi_len, .lo_len, .clk_tick, .wave_in);
  deadband_prs u_dut (.sys_clk, .rst, .clk_tick, .wave_in, .force_low, .force_low_ext,
    .chain_in(1'b0), .chain_fb_in(1'b0), .ctrl, .primary_phase_out(prim),
    .complementary_phase_out(comp), .chain_out, .chain_fb_out(), .irq, .rd_data,
    .stream_data(s_data), .stream_valid(s_valid), .stream_ready, .stream_overflow(ovf));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = !sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // sel: 0 period, 1 polynomial, 2 seed, 3 shift register read, 4 capture read
  task automatic wr(input int sel, input logic [7:0] v);
    @(posedge sys_clk);
    strb <= 5'h01 << sel;
    wd   <= v;
    @(posedge sys_clk);
    strb <= 5'h00;
  endtask : wr
  task automatic wait_wave(input logic v);
    for (int i = 0; i < 3000 && wave_in !== v; i++) @(negedge sys_clk);
  endtask : wait_wave
  // counts ticks still ahead of the watched output rising: 0 primary, 1 comp, 2 irq
  task automatic count_ticks(input int sel);
    n = 0;
    for (int i = 0; i < 3000; i++) begin
      if ((sel == 0 ? prim : sel == 1 ? comp : irq) === 1'b1) break;
      if (clk_tick) n++;
      @(negedge sys_clk);
    end
  endtask : count_ticks
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 60000) begin
      errors++;
      results();
    end
  end
  initial begin
    {rst, en, prs, run, force_low, force_low_ext, stream_ready} = 7'h40;
    {strb, wd, hi_len, lo_len} = '0;
    void'($urandom(32'hC758));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int it = 0; it < 6; it++) begin
      p = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($urandom % 24);
      @(posedge sys_clk);
      force_low <= 1'b1;
      en        <= 1'b0;
      run       <= 1'b0;
      wr(0, p);
      hi_len <= {1'b0, p} + 9'h003 + 9'($urandom % 6);
      lo_len <= {1'b0, p} + 9'h003 + 9'($urandom % 6);
      run    <= 1'b1;
      @(posedge sys_clk);
      force_low <= 1'b0;
      en        <= 1'b1;
      wait_wave(1'b1);
      count_ticks(0);
      check(16'(n), 16'(p) + 16'h0001);
      wait_wave(1'b0);
      count_ticks(1);
      check(16'(n), 16'(p) + 16'h0001);
      @(posedge sys_clk);
      force_low <= 1'b1;
      repeat (2) @(negedge sys_clk);
      check(16'({prim, comp}), 16'h0000);
      @(posedge sys_clk);
      force_low     <= 1'b0;
      force_low_ext <= 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      check(16'({prim, comp}), 16'h0000);
      @(posedge sys_clk);
      force_low_ext <= 1'b0;
      en            <= 1'b0;
      repeat (2) @(negedge sys_clk);
      check(16'({prim, comp, chain_out, irq}), 16'h0000);
      $display("dead-band test %0d done", it);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      prs <= 1'b1;
      run <= 1'b0;
      wr(1, k == 0 ? 8'h8E : 8'h30);
      seed = 8'($urandom % 63) + 8'h01;
      wr(2, seed);
      wr(3, 8'h00);
      @(negedge sys_clk);
      check(16'(rd_data), 16'h0000);
      wr(4, 8'h00);
      @(negedge sys_clk);
      check(16'(rd_data), 16'(seed));
      @(posedge sys_clk);
      en <= 1'b1;
      count_ticks(2);
      @(negedge sys_clk);
      count_ticks(2);
      check(16'(n), k == 0 ? 16'h00FF : 16'h003F);
      @(posedge sys_clk);
      en <= 1'b0;
      $display("random test %0d done", k);
    end
    @(posedge sys_clk);
    stream_ready <= 1'b1;
    @(negedge sys_clk);
    check(16'(ovf), 16'h0001);
    n = 0;
    for (int i = 0; i < 100 && s_valid === 1'b1; i++) begin
      n++;
      @(negedge sys_clk);
    end
    check(16'(n), 16'h0020);
    $display("buffer test done");
    results();
  end
endmodule : tb
